// ===== core/bdp_ram_top.sv
/*
  Dual-port block RAM: one 512 x 36 bit store reached by two ports of
  independent width, plus an AXI4-Lite slave for modes and status.
  Assumes both ports and the slave share aclk; port fabric on the same clock.
*/
`timescale 1ns/1ps

module bdp_port #(
  parameter int                 WIDTH    = 36,
  parameter bdp_pkg::bdp_rsp_t  INIT_VAL = '0,
  parameter bdp_pkg::bdp_rsp_t  SET_VAL  = '0
) (
  input  logic                          mem_clk,
  input  logic                          aresetn,
  input  bdp_pkg::bdp_req_t             req,
  input  bdp_pkg::bdp_mode_t            mode,
  input  bdp_pkg::bdp_inv_t             inv,
  input  bdp_pkg::bdp_rsp_t             old_w,
  input  bdp_pkg::bdp_rsp_t             base_w,
  output logic                          wr,
  output logic [bdp_pkg::IDX_W-1:0]     idx,
  output bdp_pkg::bdp_rsp_t             new_w,
  output bdp_pkg::bdp_rsp_t             mask_w,
  output bdp_pkg::bdp_rsp_t             rsp
);
  localparam int DW = bdp_pkg::data_w(WIDTH);
  localparam int PW = bdp_pkg::par_w(WIDTH);
  localparam int LB = $clog2(bdp_pkg::DATA_W / DW);
  localparam logic [31:0] DMASK = 32'hffff_ffff >> (bdp_pkg::DATA_W - DW);
  localparam logic [3:0]  PMASK = 4'(32'hf >> (bdp_pkg::PAR_W - PW));
  localparam logic [4:0]  LMASK = 5'((32'h1 << LB) - 32'h1);

  logic                 en;
  logic                 we;
  logic                 set;
  logic [4:0]           lane;
  logic [4:0]           off;
  logic [1:0]           poff;
  bdp_pkg::bdp_rsp_t    rd_old;
  bdp_pkg::bdp_rsp_t    wr_in;
  bdp_pkg::bdp_rsp_t    nxt_rsp;
  bdp_pkg::bdp_rsp_t    rsp_ff;

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign en   = req.en ^ inv.en;
  assign we   = req.we ^ inv.we;
  assign set  = req.set ^ inv.set;
  assign lane = req.addr[4:0] & LMASK;
  assign idx  = req.addr[LB +: bdp_pkg::IDX_W];
  assign off  = 5'(lane * DW);
  assign poff = 2'(lane * PW);
  assign wr   = en & we;

  // Widths below 9 carry no parity lane and so miss the parity bits
  assign rd_old.rdata = (old_w.rdata >> off) & DMASK;
  assign rd_old.rpar  = (old_w.rpar >> poff) & PMASK;
  assign wr_in.rdata  = req.wdata & DMASK;
  assign wr_in.rpar   = req.wpar & PMASK;
  assign mask_w.rdata = DMASK << off;
  assign mask_w.rpar  = PMASK << poff;
  assign new_w.rdata  = (base_w.rdata & ~mask_w.rdata) | (wr_in.rdata << off);
  assign new_w.rpar   = (base_w.rpar & ~mask_w.rpar) | (wr_in.rpar << poff);

  // ****************************************************************
  // Output register
  // ****************************************************************
  always_comb
  begin
    nxt_rsp = rsp_ff;
    if (en)
    begin
      if (set)
        nxt_rsp = SET_VAL;
      else if (!we)
        nxt_rsp = rd_old;
      else
      begin
        unique case (mode)
          bdp_pkg::BDP_WRITE_FIRST: nxt_rsp = wr_in;
          bdp_pkg::BDP_READ_FIRST:  nxt_rsp = rd_old;
          bdp_pkg::BDP_NO_CHANGE:   nxt_rsp = rsp_ff;
          default:                  nxt_rsp = wr_in;
        endcase
      end
    end
  end

  always_ff @(posedge mem_clk)
  begin
    if (!aresetn)
      rsp_ff <= INIT_VAL;
    else
      rsp_ff <= nxt_rsp;
  end

  assign rsp = rsp_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_set_loads: assert property (@(posedge mem_clk) disable iff (!aresetn)
    en && set |=> rsp_ff == SET_VAL) else $error("set value not loaded");
  a_idle_holds: assert property (@(posedge mem_clk) disable iff (!aresetn)
    !en |=> $stable(rsp_ff)) else $error("disabled port changed output");
  a_read_loads: assert property (@(posedge mem_clk) disable iff (!aresetn)
    en && !set && !we |=> rsp_ff == $past(rd_old)) else $error("read data wrong");
  a_wfirst_out: assert property (@(posedge mem_clk) disable iff (!aresetn)
    wr && !set && mode == bdp_pkg::BDP_WRITE_FIRST |=> rsp_ff == $past(wr_in))
    else $error("write-through output wrong");
  a_rfirst_out: assert property (@(posedge mem_clk) disable iff (!aresetn)
    wr && !set && mode == bdp_pkg::BDP_READ_FIRST |=> rsp_ff == $past(rd_old))
    else $error("read-before-write output wrong");
  a_nochg_out: assert property (@(posedge mem_clk) disable iff (!aresetn)
    wr && !set && mode == bdp_pkg::BDP_NO_CHANGE |=> $stable(rsp_ff))
    else $error("hold mode output changed");
  a_reset_init: assert property (@(posedge mem_clk)
    !aresetn |=> rsp_ff == INIT_VAL) else $error("initial output wrong");
  c_port_set: cover property (@(posedge mem_clk) disable iff (!aresetn)
    en && set);
endmodule

module bdp_ram_top #(
  parameter int                 A_WIDTH      = 36,
  parameter int                 B_WIDTH      = 9,
  parameter bit                 PORT_CLK_INV = 1'b0,
  parameter bdp_pkg::bdp_rsp_t  A_INIT       = '0,
  parameter bdp_pkg::bdp_rsp_t  A_SET        = '0,
  parameter bdp_pkg::bdp_rsp_t  B_INIT       = '0,
  parameter bdp_pkg::bdp_rsp_t  B_SET        = '0,
  parameter bdp_pkg::bdp_rsp_t  memory_initial_contents = '0,
  parameter logic [31:0]        CFG_RESET    = 32'h0000_0000
) (
  input  logic                          aclk,
  input  logic                          aresetn,
  input  logic [bdp_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  logic                          s_axi_awvalid,
  output logic                          s_axi_awready,
  input  logic [31:0]                   s_axi_wdata,
  input  logic [3:0]                    s_axi_wstrb,
  input  logic                          s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  logic                          s_axi_bready,
  input  logic [bdp_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  logic                          s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  logic                          s_axi_rready,
  input  bdp_pkg::bdp_req_t             port_a_req,
  output bdp_pkg::bdp_rsp_t             port_a_rsp,
  input  bdp_pkg::bdp_req_t             port_b_req,
  output bdp_pkg::bdp_rsp_t             port_b_rsp
);
  localparam int HI = bdp_pkg::AXI_AW - 1;

  logic                          mem_clk;
  logic                          wr_a;
  logic                          wr_b;
  logic [bdp_pkg::IDX_W-1:0]     idx_a;
  logic [bdp_pkg::IDX_W-1:0]     idx_b;
  bdp_pkg::bdp_rsp_t             old_a;
  bdp_pkg::bdp_rsp_t             old_b;
  bdp_pkg::bdp_rsp_t             base_b;
  bdp_pkg::bdp_rsp_t             new_a;
  bdp_pkg::bdp_rsp_t             new_b;
  bdp_pkg::bdp_rsp_t             mask_a;
  bdp_pkg::bdp_rsp_t             mask_b;
  logic                          same_idx;
  logic                          overlap;
  logic                          coll_ff;
  bdp_pkg::bdp_rsp_t             mem_ff [bdp_pkg::DEPTH] =
                                   '{default: memory_initial_contents};
  logic                          aw_ff;
  logic                          w_ff;
  logic [HI:0]                   awaddr_ff;
  logic [31:0]                   wdata_ff;
  logic [3:0]                    wstrb_ff;
  logic                          bvalid_ff;
  logic [1:0]                    bresp_ff;
  logic                          rvalid_ff;
  logic [31:0]                   rdata_ff;
  logic [1:0]                    rresp_ff;
  logic [31:0]                   cfg_ff;
  logic                          stat_ff;
  logic                          wr_go;
  logic                          ar_go;
  logic                          cfg_hit;
  logic                          stat_hit;
  logic                          ar_cfg;
  logic                          ar_stat;
  logic [31:0]                   wmask;
  logic [31:0]                   nxt_cfg;
  logic                          stat_clr;
  logic                          nxt_stat;

  // ****************************************************************
  // Shared store
  // ****************************************************************
  assign mem_clk  = aclk ^ PORT_CLK_INV;
  assign old_a    = mem_ff[idx_a];
  assign old_b    = mem_ff[idx_b];
  assign same_idx = idx_a == idx_b;
  // B merges over A's update so lanes of one word written together both land
  assign base_b   = (wr_a && same_idx) ? new_a : old_b;
  assign overlap  = wr_a & wr_b & same_idx & (|(mask_a & mask_b));

  bdp_port #(
    .WIDTH    (A_WIDTH),
    .INIT_VAL (A_INIT),
    .SET_VAL  (A_SET)
  ) u_port_a (
    .mem_clk  (mem_clk),
    .aresetn  (aresetn),
    .req      (port_a_req),
    .mode     (bdp_pkg::bdp_mode_t'(cfg_ff[bdp_pkg::CFG_A_MODE +: 2])),
    .inv      (bdp_pkg::bdp_inv_t'(cfg_ff[bdp_pkg::CFG_A_INV +: 3])),
    .old_w    (old_a),
    .base_w   (old_a),
    .wr       (wr_a),
    .idx      (idx_a),
    .new_w    (new_a),
    .mask_w   (mask_a),
    .rsp      (port_a_rsp)
  );

  bdp_port #(
    .WIDTH    (B_WIDTH),
    .INIT_VAL (B_INIT),
    .SET_VAL  (B_SET)
  ) u_port_b (
    .mem_clk  (mem_clk),
    .aresetn  (aresetn),
    .req      (port_b_req),
    .mode     (bdp_pkg::bdp_mode_t'(cfg_ff[bdp_pkg::CFG_B_MODE +: 2])),
    .inv      (bdp_pkg::bdp_inv_t'(cfg_ff[bdp_pkg::CFG_B_INV +: 3])),
    .old_w    (old_b),
    .base_w   (base_b),
    .wr       (wr_b),
    .idx      (idx_b),
    .new_w    (new_b),
    .mask_w   (mask_b),
    .rsp      (port_b_rsp)
  );

  always_ff @(posedge mem_clk)
  begin
    if (wr_a)
      mem_ff[idx_a] <= new_a;
    if (wr_b)
      mem_ff[idx_b] <= new_b;
  end

  always_ff @(posedge mem_clk)
  begin
    if (!aresetn)
      coll_ff <= 1'b0;
    else
      coll_ff <= overlap;
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign wr_go    = aw_ff & w_ff;
  assign ar_go    = s_axi_arvalid & ~rvalid_ff;
  assign cfg_hit  = awaddr_ff[HI:2] == bdp_pkg::CFG_OFFSET[HI:2];
  assign stat_hit = awaddr_ff[HI:2] == bdp_pkg::STAT_OFFSET[HI:2];
  assign ar_cfg   = s_axi_araddr[HI:2] == bdp_pkg::CFG_OFFSET[HI:2];
  assign ar_stat  = s_axi_araddr[HI:2] == bdp_pkg::STAT_OFFSET[HI:2];
  assign wmask    = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                     {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign nxt_cfg  = (wr_go && cfg_hit) ?
                    ((cfg_ff & ~wmask) | (wdata_ff & wmask)) & bdp_pkg::CFG_MASK :
                    cfg_ff;
  assign stat_clr = wr_go & stat_hit & wstrb_ff[0] & wdata_ff[bdp_pkg::STAT_COLL];
  // A collision in the clearing cycle keeps the flag set
  assign nxt_stat = (stat_ff & ~stat_clr) | coll_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
    end
    else
    begin
      aw_ff <= (aw_ff | s_axi_awvalid & s_axi_awready) & ~wr_go;
      w_ff  <= (w_ff | s_axi_wvalid & s_axi_wready) & ~wr_go;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        awaddr_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= bdp_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (cfg_hit | stat_hit) ? bdp_pkg::RESP_OKAY : bdp_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= bdp_pkg::RESP_OKAY;
    end
    else if (ar_go)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= ar_cfg ? cfg_ff : (ar_stat ? 32'(stat_ff) : '0);
      rresp_ff  <= (ar_cfg | ar_stat) ? bdp_pkg::RESP_OKAY : bdp_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff  <= CFG_RESET & bdp_pkg::CFG_MASK;
      stat_ff <= 1'b0;
    end
    else
    begin
      cfg_ff  <= nxt_cfg;
      stat_ff <= nxt_stat;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_write_stores: assert property (@(posedge mem_clk) disable iff (!aresetn)
    wr_a && !wr_b |=> (mem_ff[$past(idx_a)] & $past(mask_a)) ==
                      ($past(new_a) & $past(mask_a)))
    else $error("port A write not stored");
  a_idle_no_store: assert property (@(posedge mem_clk) disable iff (!aresetn)
    !wr_a && !wr_b |=> mem_ff[$past(idx_a)] == $past(old_a))
    else $error("store changed without a write");
  a_coll_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    coll_ff |=> stat_ff ##1 (stat_ff || $past(stat_clr))) else $error("collision flag lost");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped");
  c_both_write: cover property (@(posedge mem_clk) disable iff (!aresetn)
    wr_a && wr_b && same_idx && !overlap);
  c_collision: cover property (@(posedge aclk) disable iff (!aresetn) coll_ff);
  c_cfg_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && cfg_hit);
endmodule

// ===== core/bdp_pkg.sv
/*
  Shared constants, field layouts and carriers of the dual-port block RAM.
  Assumes one 32-bit AXI4-Lite register slave beside the memory ports.
*/
package bdp_pkg;
  // ****************************************************************
  // Storage geometry
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int PAR_W  = 4;
  localparam int ADDR_W = 14;
  localparam int IDX_W  = 9;
  localparam int DEPTH  = 512;
  localparam int PAR_STEP = 9;
  localparam int PAR_DATA = 8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int AXI_AW = 32;
  localparam logic [AXI_AW-1:0] CFG_OFFSET  = 32'h0000_0000;
  localparam logic [AXI_AW-1:0] STAT_OFFSET = 32'h0000_0004;
  localparam int CFG_A_MODE = 0;
  localparam int CFG_B_MODE = 2;
  localparam int CFG_A_INV  = 4;
  localparam int CFG_B_INV  = 8;
  localparam logic [31:0] CFG_MASK = 32'h0000_077f;
  localparam int STAT_COLL  = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BDP_WRITE_FIRST = 2'b00,
    BDP_READ_FIRST  = 2'b01,
    BDP_NO_CHANGE   = 2'b10
  } bdp_mode_t;

  typedef struct packed {
    logic              set;
    logic              we;
    logic              en;
  } bdp_inv_t;

  typedef struct packed {
    logic              en;
    logic              we;
    logic              set;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [PAR_W-1:0]  wpar;
  } bdp_req_t;

  typedef struct packed {
    logic [PAR_W-1:0]  rpar;
    logic [DATA_W-1:0] rdata;
  } bdp_rsp_t;

  function automatic int data_w(int w);
    return (w >= PAR_STEP) ? (w / PAR_STEP) * PAR_DATA : w;
  endfunction

  function automatic int par_w(int w);
    return w / PAR_STEP;
  endfunction
endpackage

// ===== dv/bdp_fabric.sv
/*
  Fabric model for one memory port: passes the bench command on, makes
  byte parity and shows an inverted data bus while not writing.
  Assumes commands change right after a rising aclk edge.
*/
`timescale 1ns/1ps
module bdp_fabric (
  input  logic              en,
  input  logic              we,
  input  logic              set,
  input  logic [13:0]       addr,
  input  logic [31:0]       data,
  output bdp_pkg::bdp_req_t req
);
  // ****************************************************************
  // Request build
  // ****************************************************************
  always_comb
  begin
    req.en    = en;
    req.we    = we;
    req.set   = set;
    req.addr  = addr;
    req.wdata = we ? data : ~data;
    for (int i = 0; i < 4; i++)
      req.wpar[i] = ^data[8*i+:8];
  end
endmodule

// ===== dv/bdp_ram_top_bench.sv
/*
  Self-checking bench: port A at 36 bits, port B at 9 bits, modes set
  over AXI4-Lite. Assumes one 200 MHz clock for bus and both ports.
*/
`timescale 1ns/1ps
module bdp_ram_top_bench;
  localparam bdp_pkg::bdp_rsp_t AI = 36'h1_2345_6789;
  localparam bdp_pkg::bdp_rsp_t AS = 36'h8_55aa_33cc;
  localparam bdp_pkg::bdp_rsp_t BI = 36'h0_0000_00a5;
  localparam bdp_pkg::bdp_rsp_t BS = 36'h3_0f0f_f0f0;
  localparam bdp_pkg::bdp_rsp_t MI = 36'h9_dead_beef;
  typedef struct {logic [35:0] v; int s;} bdp_note_t;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       awaddr, wdata, araddr, rdata, d;
  logic [1:0]        bresp, rresp;
  logic              a_en, a_we, a_set, b_en, b_we, b_set;
  logic [13:0]       a_addr, b_addr, ad;
  logic [31:0]       a_d, b_d;
  logic [35:0]       sb [512];
  logic [35:0]       ra, rcap, bcap, e;
  bdp_pkg::bdp_req_t areq, breq;
  bdp_pkg::bdp_rsp_t arsp, brsp;
  bdp_note_t         q [$];
  bdp_note_t         nt;
  int                err_count, n_tests;
  string             nm [4] = '{"port_a_rsp", "port_b_rsp", "axi_read", "axi_bresp"};

  bdp_fabric fa (.en(a_en), .we(a_we), .set(a_set), .addr(a_addr), .data(a_d), .req(areq));
  bdp_fabric fb (.en(b_en), .we(b_we), .set(b_set), .addr(b_addr), .data(b_d), .req(breq));
  bdp_ram_top #(.A_INIT(AI), .A_SET(AS), .B_INIT(BI), .B_SET(BS),
    .memory_initial_contents(MI)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_req(areq), .port_a_rsp(arsp), .port_b_req(breq), .port_b_rsp(brsp));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [35:0] wrd(logic [31:0] x);
    return {^x[31:24], ^x[23:16], ^x[15:8], ^x[7:0], x};
  endfunction

  function automatic logic [35:0] bval(logic [35:0] w, int l);
    return {3'h0, w[32+l], 24'h0, w[8*l+:8]};
  endfunction

  task automatic chk(input string s, input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] x);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= x;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    q.push_back('{36'((a == bdp_pkg::CFG_OFFSET || a == bdp_pkg::STAT_OFFSET) ?
                      bdp_pkg::RESP_OKAY : bdp_pkg::RESP_SLVERR), 3});
  endtask

  task automatic axr(input logic [31:0] a, input logic [35:0] x);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    q.push_back('{x, 2});
  endtask

  // Drive one enabled or disabled edge on a port, then note the result
  task automatic op(input int p, input logic en, input logic we, input logic st,
                    input logic [13:0] a, input logic [31:0] x, input logic [35:0] ex);
    @(posedge aclk);
    if (p == 0) {a_en, a_we, a_set, a_addr, a_d} <= {en, we, st, a, x};
    else {b_en, b_we, b_set, b_addr, b_d} <= {en, we, st, a, x};
    @(posedge aclk);
    if (p == 0) {a_en, a_we} <= 2'h0;
    else {b_en, b_we} <= 2'h0;
    if (p == 0) ra = ex;
    q.push_back('{ex, p});
  endtask

  // ****************************************************************
  // Clock, watchdog, monitor
  // ****************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_count++;
    results;
  end

  always @(posedge aclk)
  begin
    if (rvalid && rready) rcap <= {2'h0, rresp, rdata};
    if (bvalid && bready) bcap <= {34'h0, bresp};
  end

  always @(negedge aclk)
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      chk(nm[nt.s], nt.s == 0 ? arsp : nt.s == 1 ? brsp : nt.s == 2 ? rcap : bcap, nt.v);
    end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    {a_en, a_we, a_set, a_addr, a_d, b_en, b_we, b_set, b_addr, b_d} = '0;
    for (int i = 0; i < 512; i++) sb[i] = MI;
    void'($urandom(32'h82e77b4d));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    q.push_back('{AI, 0});
    q.push_back('{BI, 1});
    axr(bdp_pkg::CFG_OFFSET, {2'h0, bdp_pkg::RESP_OKAY, 32'h0});
    op(0, 1, 0, 0, 14'h3c1, 32'h0, MI);
    done("reset");
    for (int m = 0; m < 4; m++)
    begin
      axw(bdp_pkg::CFG_OFFSET, 32'(m));
      ad = 14'($urandom);
      d = $urandom;
      e = (m == 1) ? sb[ad[8:0]] : (m == 2) ? ra : wrd(d);
      op(0, 1, 1, 0, ad, d, e);
      sb[ad[8:0]] = wrd(d);
      op(0, 1, 0, 0, ad, ~d, wrd(d));
    end
    done("modes");
    axw(bdp_pkg::CFG_OFFSET, 32'h0);
    op(0, 1, 0, 1, 14'h5, 32'h0, AS);
    op(0, 0, 1, 1, 14'h5, d, AS);
    op(0, 1, 0, 0, 14'h5, 32'h0, sb[5]);
    op(1, 1, 0, 1, 14'h7, 32'h0, BS);
    done("set and enable");
    for (int l = 0; l < 4; l++)
      op(1, 1, 0, 0, 14'({ad[8:0], 2'(l)}), 32'h0, bval(sb[ad[8:0]], l));
    d = $urandom;
    op(1, 1, 1, 0, 14'({ad[8:0], 2'h2}), d, {3'h0, ^d[7:0], 24'h0, d[7:0]});
    sb[ad[8:0]][23:16] = d[7:0];
    sb[ad[8:0]][34] = ^d[7:0];
    op(0, 1, 0, 0, ad, 32'h0, sb[ad[8:0]]);
    done("width conversion");
    axw(bdp_pkg::CFG_OFFSET, 32'hffff_f810);
    axr(bdp_pkg::CFG_OFFSET, {2'h0, bdp_pkg::RESP_OKAY, 32'h10});
    d = $urandom;
    op(0, 1, 1, 0, 14'h9, d, sb[a_addr[8:0]]);
    op(0, 0, 1, 0, 14'h9, d, wrd(d));
    axw(bdp_pkg::CFG_OFFSET, 32'h0);
    op(0, 1, 0, 0, 14'h9, 32'h0, wrd(d));
    axr(32'h0000_0010, {2'h0, bdp_pkg::RESP_SLVERR, 32'h0});
    done("inversion and bus");
    // Both ports write byte lane 0 of word 9 on one edge
    d = $urandom;
    @(posedge aclk);
    {a_en, a_we, a_set, a_addr, a_d} <= {3'h6, 14'h9, d};
    {b_en, b_we, b_set, b_addr, b_d} <= {3'h6, 14'h24, ~d};
    @(posedge aclk);
    {a_en, a_we, b_en, b_we} <= 4'h0;
    q.push_back('{wrd(d), 0});
    q.push_back('{bval(wrd(~d), 0), 1});
    axr(bdp_pkg::STAT_OFFSET, {2'h0, bdp_pkg::RESP_OKAY, 32'h1});
    axw(bdp_pkg::STAT_OFFSET, 32'h1);
    axr(bdp_pkg::STAT_OFFSET, {2'h0, bdp_pkg::RESP_OKAY, 32'h0});
    axw(32'h0000_0010, 32'h0);
    op(1, 1, 0, 0, 14'h24, 32'h0, bval(wrd(~d), 0));
    done("collision and status");
    repeat (2) @(posedge aclk);
    results;
  end
endmodule
